// ### hw/tx_ctrl_pkg.sv
package tx_ctrl_pkg;
	// control register (top-level) bit positions
	localparam int CTRL_RESET_N_BIT  = 0;
	localparam int CTRL_PD_TX_BIT    = 1;
	localparam int CTRL_PD_SYNTH_BIT = 2;
	localparam int CTRL_PD_XOSC_BIT  = 3;
	localparam int CTRL_PDMODE_LSB   = 4;
	localparam int CTRL_FSEL_BIT     = 6;
	localparam logic [7:0] CTRL_RESET = 8'h0F;
	// modulator settings register
	localparam int MOD_TPE_BIT       = 0;
	localparam int MOD_SYNC_BIT      = 1;
	localparam logic [7:0] MOD_RESET = 8'h00;
	// interface register
	localparam int IF_LOCKIND_BIT    = 0;
	localparam int IF_BYPASS_BIT     = 1;
	localparam logic [7:0] IF_RESET  = 8'h00;
	localparam logic [7:0] OSC_RESET = 8'h88;
	localparam logic [7:0] BUF_RESET = 8'h10;
	// device register addresses
	localparam logic [2:0] ADDR_CTRL  = 3'h0;
	localparam logic [2:0] ADDR_MOD   = 3'h1;
	localparam logic [2:0] ADDR_IF    = 3'h2;
	localparam logic [2:0] ADDR_OSC   = 3'h3;
	localparam logic [2:0] ADDR_BUF   = 3'h4;
	localparam logic [2:0] ADDR_STAT  = 3'h5;
	// host software-port addresses
	localparam logic [3:0] HADDR_WADDR = 4'h0;
	localparam logic [3:0] HADDR_WDATA = 4'h1;
	localparam logic [3:0] HADDR_DATA  = 4'h2;
	localparam logic [3:0] HADDR_STAT  = 4'h3;
	localparam logic [3:0] HADDR_MASK  = 4'h4;
	localparam logic [3:0] HADDR_RDATA = 4'h5;
	localparam logic [1:0] PD_NORMAL  = 2'h0;
	localparam logic [1:0] PD_LOCKIND = 2'h1;
	// timing
	localparam int CLK_MHZ        = 40;
	localparam int TURNON_MAX_US  = 3200;
	localparam int TURNON_MIN_US  = 700;
	localparam int TURNON_CYCLES  = TURNON_MAX_US * CLK_MHZ;
	localparam int RELOCK_US      = 180;
	localparam int RELOCK_CYCLES  = RELOCK_US * CLK_MHZ;
	localparam int SYMBOL_DIV     = 260;
	localparam logic [8:0] PN_SEED = 9'h1FF;
endpackage

// ### hw/tx_link_if.sv
interface tx_link_if;
	logic       cfgWe;
	logic [2:0] cfgAddr;
	logic [7:0] cfgWdata;
	logic [7:0] cfgRdata;
	logic       txData;
	logic       strobeOut;
	logic       strobeOe;
	logic       dataClock;
	modport device (input cfgWe, input cfgAddr, input cfgWdata, output cfgRdata,
		input txData, input strobeOut, input strobeOe, output dataClock);
	modport host (output cfgWe, output cfgAddr, output cfgWdata, input cfgRdata,
		output txData, output strobeOut, output strobeOe, input dataClock);
endinterface

// ### hw/pn9_gen.sv
module pn9_gen
	import tx_ctrl_pkg::*;
(
	// clock and reset
	input  wire logic core_clk,
	input  wire logic rst,
	// control
	input  wire logic restart,
	input  wire logic advance,
	// pattern
	output logic      bitOut
);
	logic [8:0] shift_q;

	// x^9 + x^5 + 1, maximal length 511
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			shift_q <= PN_SEED;
		end else if (restart) begin
			shift_q <= PN_SEED;
		end else if (advance) begin
			shift_q <= {shift_q[7:0], shift_q[8] ^ shift_q[4]};
		end
	end

	assign bitOut = shift_q[8];
endmodule // pn9_gen

// ### hw/tx_device.sv
// Implementation choices: the placing of the registers and register access by write enable, with the strobe inputs unused.
module tx_device
	import tx_ctrl_pkg::*;
#(
	parameter int TURNON = TURNON_CYCLES,
	parameter int RELOCK = RELOCK_CYCLES,
	parameter int SYMDIV = SYMBOL_DIV
) (
	// clock and reset
	input  wire logic core_clk,
	input  wire logic rst,
	// link
	tx_link_if.device link,
	// analog-facing outputs
	output logic      modBit,
	output logic      txPowered,
	output logic      synthPowered,
	output logic      oscPowered,
	output logic      oscBypass,
	output logic [3:0] oscCurrent,
	output logic [7:0] bufferBias,
	output logic      pllLocked
);
	// symbol counter is 16 bits wide
	if (TURNON < 1 || RELOCK < 1 || SYMDIV < 2 || SYMDIV > 65536) begin : g_bad_param
		$error("bad timing parameter");
	end

	logic [7:0] ctrl_q, mod_q, if_q, osc_q, buf_q;
	logic [7:0] rdata_q;
	logic [31:0] lockCnt_q;
	logic        lockRaw_q, lockS1_q, lockS2_q;
	logic        fselPrev_q;
	logic [15:0] symCnt_q;
	logic        symTick;
	logic        data1_q, data2_q, dataPrev_q, armed_q, waitEdge_q;
	logic        data_clock_output_q, pnBit;
	logic        softReset;
	logic        synthOn;

	assign softReset = !ctrl_q[CTRL_RESET_N_BIT];
	assign synthOn   = !ctrl_q[CTRL_PD_SYNTH_BIT] && !ctrl_q[CTRL_PD_XOSC_BIT];

	// each write lands only in its own register
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			ctrl_q <= CTRL_RESET;
			mod_q  <= MOD_RESET;
			if_q   <= IF_RESET;
			osc_q  <= OSC_RESET;
			buf_q  <= BUF_RESET;
		end else if (link.cfgWe) begin
			case (link.cfgAddr)
				ADDR_CTRL: ctrl_q <= link.cfgWdata;
				ADDR_MOD:  mod_q  <= softReset ? MOD_RESET : link.cfgWdata;
				ADDR_IF:   if_q   <= softReset ? IF_RESET : link.cfgWdata;
				ADDR_OSC:  osc_q  <= softReset ? OSC_RESET : link.cfgWdata;
				ADDR_BUF:  buf_q  <= softReset ? BUF_RESET : link.cfgWdata;
				default: ;
			endcase
		end else if (softReset) begin
			mod_q <= MOD_RESET;
			if_q  <= IF_RESET;
			osc_q <= OSC_RESET;
			buf_q <= BUF_RESET;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			rdata_q <= 8'h00;
		end else begin
			case (link.cfgAddr)
				ADDR_CTRL: rdata_q <= ctrl_q;
				ADDR_MOD:  rdata_q <= mod_q;
				ADDR_IF:   rdata_q <= if_q;
				ADDR_OSC:  rdata_q <= osc_q;
				ADDR_BUF:  rdata_q <= buf_q;
				ADDR_STAT: rdata_q <= {7'h00, lockS2_q};
				default:   rdata_q <= 8'h00;
			endcase
		end
	end
	assign link.cfgRdata = rdata_q;

	// behavioural lock: counts from power-up or frequency switch
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			lockCnt_q  <= 32'h0000_0000;
			lockRaw_q  <= 1'b0;
			fselPrev_q <= 1'b0;
		end else begin
			fselPrev_q <= ctrl_q[CTRL_FSEL_BIT];
			if (!synthOn || softReset) begin
				lockCnt_q <= TURNON[31:0];
				lockRaw_q <= 1'b0;
			end else if (fselPrev_q != ctrl_q[CTRL_FSEL_BIT]) begin
				lockCnt_q <= RELOCK[31:0];
				lockRaw_q <= 1'b0;
			end else if (lockCnt_q != 32'h0000_0000) begin
				lockCnt_q <= lockCnt_q - 32'h0000_0001;
			end else begin
				lockRaw_q <= 1'b1;
			end
		end
	end

	// two stages so the pin never sees a raw transition
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			lockS1_q <= 1'b0;
			lockS2_q <= 1'b0;
		end else begin
			lockS1_q <= lockRaw_q;
			lockS2_q <= lockS1_q;
		end
	end

	// symbol rate enable
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			symCnt_q <= 16'h0000;
		end else if (symTick) begin
			symCnt_q <= 16'h0000;
		end else begin
			symCnt_q <= symCnt_q + 16'h0001;
		end
	end
	assign symTick = (symCnt_q == 16'(SYMDIV - 1));

	// host data pin is outside our timing: synchronise first
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			data1_q    <= 1'b0;
			data2_q    <= 1'b0;
			dataPrev_q <= 1'b0;
		end else begin
			data1_q    <= link.txData;
			data2_q    <= data1_q;
			dataPrev_q <= data2_q;
		end
	end

	// generator waits for a data edge after being enabled
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			armed_q    <= 1'b0;
			waitEdge_q <= 1'b0;
		end else if (!mod_q[MOD_TPE_BIT]) begin
			armed_q    <= 1'b0;
			waitEdge_q <= 1'b0;
		end else if (!armed_q && !waitEdge_q) begin
			waitEdge_q <= 1'b1;
		end else if (waitEdge_q && (data2_q != dataPrev_q)) begin
			waitEdge_q <= 1'b0;
			armed_q    <= 1'b1;
		end
	end

	pn9_gen i_pn9_gen (
		.core_clk (core_clk),
		.rst      (rst),
		.restart  (!armed_q),
		.advance  (armed_q && symTick),
		.bitOut   (pnBit)
	);

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			modBit <= 1'b0;
		end else if (symTick) begin
			modBit <= mod_q[MOD_TPE_BIT] ? (armed_q & pnBit) : data2_q;
		end
	end

	// data clock: lock indicate or normal symbol clock
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			data_clock_output_q <= 1'b0;
		end else if (mod_q[MOD_SYNC_BIT] && if_q[IF_LOCKIND_BIT]
				&& ctrl_q[CTRL_PDMODE_LSB +: 2] == PD_LOCKIND) begin
			data_clock_output_q <= !lockS2_q;
		end else if (!mod_q[MOD_SYNC_BIT]) begin
			data_clock_output_q <= 1'b0;
		end else if (symTick) begin
			data_clock_output_q <= !data_clock_output_q;
		end
	end
	assign link.dataClock = data_clock_output_q;

	// outputs from registers
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			txPowered    <= 1'b0;
			synthPowered <= 1'b0;
			oscPowered   <= 1'b0;
			oscBypass    <= 1'b0;
			oscCurrent   <= 4'h0;
			bufferBias   <= 8'h00;
			pllLocked    <= 1'b0;
		end else begin
			txPowered    <= !ctrl_q[CTRL_PD_TX_BIT];
			synthPowered <= !ctrl_q[CTRL_PD_SYNTH_BIT];
			oscPowered   <= !ctrl_q[CTRL_PD_XOSC_BIT];
			oscBypass    <= if_q[IF_BYPASS_BIT];
			oscCurrent   <= ctrl_q[CTRL_FSEL_BIT] ? osc_q[7:4] : osc_q[3:0];
			bufferBias   <= buf_q;
			pllLocked    <= lockS2_q;
		end
	end
endmodule // tx_device

// ### hw/tx_host.sv
module tx_host
	import tx_ctrl_pkg::*;
(
	// clock and reset
	input  wire logic core_clk,
	input  wire logic rst,
	// software port
	input  wire logic [3:0] addr,
	input  wire logic [7:0] wdata,
	input  wire logic       wr,
	input  wire logic       rd,
	output logic      [7:0] rdata,
	output logic            irq,
	// link
	tx_link_if.host link
);
	logic [2:0] waddr_q;
	logic       we_q, txd_q, dc1_q, dc2_q, dcPrev_q;
	logic [7:0] wd_q, stat_q, mask_q;

	// writing the write-data register issues one device write
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			waddr_q <= 3'h0;
			wd_q    <= 8'h00;
			we_q    <= 1'b0;
			txd_q   <= 1'b0;
			mask_q  <= 8'h00;
		end else begin
			we_q <= wr && addr == HADDR_WDATA;
			if (wr && addr == HADDR_WADDR) waddr_q <= wdata[2:0];
			if (wr && addr == HADDR_WDATA) wd_q <= wdata;
			if (wr && addr == HADDR_DATA) txd_q <= wdata[0];
			if (wr && addr == HADDR_MASK) mask_q <= wdata;
		end
	end
	assign link.cfgWe    = we_q;
	assign link.cfgAddr  = waddr_q;
	assign link.cfgWdata = wd_q;
	assign link.txData   = txd_q;
	assign link.strobeOut = 1'b1;
	assign link.strobeOe  = 1'b1;

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			dc1_q    <= 1'b0;
			dc2_q    <= 1'b0;
			dcPrev_q <= 1'b0;
		end else begin
			dc1_q    <= link.dataClock;
			dc2_q    <= dc1_q;
			dcPrev_q <= dc2_q;
		end
	end

	// bit0 lock seen (falling data clock); set wins over read clear
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			stat_q <= 8'h00;
		end else begin
			stat_q <= ((rd && addr == HADDR_STAT) ? 8'h00 : stat_q)
				| {7'h00, dcPrev_q & !dc2_q};
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			rdata <= 8'h00;
			irq   <= 1'b0;
		end else begin
			irq <= |(stat_q & mask_q);
			case (addr)
				HADDR_STAT:  rdata <= rd ? stat_q : 8'h00;
				HADDR_MASK:  rdata <= rd ? mask_q : 8'h00;
				HADDR_RDATA: rdata <= rd ? link.cfgRdata : 8'h00;
				default:     rdata <= 8'h00;
			endcase
		end
	end
endmodule // tx_host

// ### verification/tx_power_pn9_lock_control_asserts.sv
module tx_power_pn9_lock_control_asserts
	import tx_ctrl_pkg::*;
#(
	parameter int TURNON = TURNON_CYCLES
) (
	// clock and reset
	input wire logic       core_clk,
	input wire logic       rst,
	// link
	input wire logic       cfgWe,
	input wire logic [2:0] cfgAddr,
	input wire logic [7:0] cfgWdata,
	input wire logic [7:0] cfgRdata,
	input wire logic       txData,
	input wire logic       strobeOut,
	input wire logic       strobeOe,
	input wire logic       dataClock
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] ctrlQ, modQ, ifQ, ageQ;
	logic       freshQ, indCfg, synthUp;
	default clocking @(posedge core_clk);
	endclocking
	default disable iff (rst);
	// shadow of the device settings, rebuilt from link writes
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			ctrlQ <= CTRL_RESET;
			modQ <= MOD_RESET;
			ifQ <= IF_RESET;
		end else if (cfgWe && cfgAddr == ADDR_CTRL) begin
			ctrlQ <= cfgWdata;
			if (!cfgWdata[CTRL_RESET_N_BIT]) begin
				modQ <= MOD_RESET;
				ifQ <= IF_RESET;
			end
		end else if (cfgWe && ctrlQ[CTRL_RESET_N_BIT]) begin
			if (cfgAddr == ADDR_MOD) modQ <= cfgWdata;
			if (cfgAddr == ADDR_IF) ifQ <= cfgWdata;
		end
	end
	// cycles since the last link write, saturating
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) ageQ <= 8'h00;
		else if (cfgWe) ageQ <= 8'h00;
		else if (ageQ != 8'hFF) ageQ <= ageQ + 8'h01;
	end
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) freshQ <= 1'b1;
		else if (cfgWe) freshQ <= 1'b0;
	end
	assign indCfg = modQ[MOD_SYNC_BIT] && ifQ[IF_LOCKIND_BIT] && ctrlQ[5:4] == PD_LOCKIND;
	assign synthUp = ctrlQ[3:2] == 2'h0 && ctrlQ[CTRL_RESET_N_BIT];
	property p_strobe;
		!$past(rst) |-> strobeOut && strobeOe;
	endproperty
	a_strobe: assert property (p_strobe) else $error("strobe not held high");
	property p_ctrl_reset;
		freshQ && ageQ >= 8'h02 && $past(cfgAddr) == ADDR_CTRL |-> cfgRdata == CTRL_RESET;
	endproperty
	a_ctrl_reset: assert property (p_ctrl_reset) else $error("ctrl reset value");
	property p_ctrl_store;
		cfgWe && cfgAddr == ADDR_CTRL ##1 (!cfgWe && $stable(cfgAddr))[*3]
			|-> cfgRdata == $past(cfgWdata, 3);
	endproperty
	a_ctrl_store: assert property (p_ctrl_store) else $error("ctrl not stored");
	property p_reg_store;
		cfgWe && ctrlQ[CTRL_RESET_N_BIT] && (cfgAddr == ADDR_OSC || cfgAddr == ADDR_BUF)
			##1 (!cfgWe && $stable(cfgAddr))[*3] |-> cfgRdata == $past(cfgWdata, 3);
	endproperty
	a_reg_store: assert property (p_reg_store) else $error("setting not stored");
	property p_ind_high;
		indCfg && !synthUp && ageQ >= 8'h08 |-> dataClock;
	endproperty
	a_ind_high: assert property (p_ind_high) else $error("clock low while unlocked");
	property p_lock_time;
		indCfg && synthUp && ageQ >= TURNON + 12 |-> !dataClock;
	endproperty
	a_lock_time: assert property (p_lock_time) else $error("no lock in time");
	property p_relock;
		cfgWe && cfgAddr == ADDR_CTRL && indCfg && synthUp && !dataClock && cfgWdata[0]
			&& cfgWdata[5:2] == 4'h4 && cfgWdata[CTRL_FSEL_BIT] != ctrlQ[CTRL_FSEL_BIT]
			|-> ##[1:8] dataClock;
	endproperty
	a_relock: assert property (p_relock) else $error("no relock on switch");
	property p_no_glitch;
		indCfg && ageQ >= 8'h08 && $changed(dataClock) |=> $stable(dataClock);
	endproperty
	a_no_glitch: assert property (p_no_glitch) else $error("lock output glitch");
endmodule // tx_power_pn9_lock_control_asserts

// ### verification/tx_power_pn9_lock_control_tb.sv
module tx_power_pn9_lock_control_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import tx_ctrl_pkg::*;
	localparam int TON = 50;
	localparam int SDIV = 4;
	logic       core_clk, rst, wr, rd, modBit, txPowered, synthPowered, oscPowered;
	logic       oscBypass, pllLocked, irq, lv;
	logic [3:0] addr, oscCurrent;
	logic [7:0] wdata, rdata, bufferBias, v;
	int         errorCnt, checks, n;
	tx_link_if link ();
	tx_device #(.TURNON(TON), .RELOCK(20), .SYMDIV(SDIV)) i_tx_device (.core_clk(core_clk),
		.rst(rst), .link(link), .modBit(modBit), .txPowered(txPowered),
		.synthPowered(synthPowered), .oscPowered(oscPowered), .oscBypass(oscBypass),
		.oscCurrent(oscCurrent), .bufferBias(bufferBias), .pllLocked(pllLocked));
	tx_host i_tx_host (.core_clk(core_clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
		.rd(rd), .rdata(rdata), .irq(irq), .link(link));
	tx_power_pn9_lock_control_asserts #(.TURNON(TON)) i_tx_power_pn9_lock_control_asserts (
		.core_clk(core_clk), .rst(rst), .cfgWe(link.cfgWe), .cfgAddr(link.cfgAddr),
		.cfgWdata(link.cfgWdata), .cfgRdata(link.cfgRdata), .txData(link.txData),
		.strobeOut(link.strobeOut), .strobeOe(link.strobeOe), .dataClock(link.dataClock));
	task automatic results();
		if (errorCnt == 0 && checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			errorCnt++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk1(input logic got, input logic exp);
		chk8({7'h00, got}, {7'h00, exp});
	endtask
	task automatic hw(input logic [3:0] a, input logic [7:0] d);
		@(posedge core_clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge core_clk);
		wr <= 1'b0;
		#1;
	endtask
	task automatic hr(input logic [3:0] a);
		@(posedge core_clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge core_clk);
		rd <= 1'b0;
		#1 v = rdata;
	endtask
	task automatic dw(input logic [2:0] a, input logic [7:0] d);
		hw(HADDR_WADDR, {5'h00, a});
		hw(HADDR_WDATA, d);
		repeat (6) @(posedge core_clk);
		#1;
	endtask
	task automatic dr(input logic [2:0] a);
		hw(HADDR_WADDR, {5'h00, a});
		repeat (3) @(posedge core_clk);
		hr(HADDR_RDATA);
	endtask
	// sel 1 watches the modulator bit, 0 the lock output
	task automatic waitFor(input int sel, input logic lvl, input int lim);
		n = 0;
		while ((sel ? modBit : link.dataClock) !== lvl) begin
			@(posedge core_clk);
			#1 n++;
			if (n > lim) begin
				errorCnt++;
				results();
			end
		end
	endtask
	task automatic t_regs();
		dr(ADDR_CTRL);
		chk8(v, CTRL_RESET);
		for (int i = 1; i < 4; i++) begin
			dw(ADDR_CTRL, CTRL_RESET ^ (8'h01 << i));
			chk8({5'h00, oscPowered, synthPowered, txPowered}, 8'h01 << (i - 1));
		end
		dw(ADDR_BUF, 8'h5A);
		dw(ADDR_IF, 8'h02);
		dw(ADDR_OSC, 8'h3C);
		dw(ADDR_CTRL, 8'h07);
		chk8(bufferBias, 8'h5A);
		chk1(oscBypass, 1'b1);
		chk8({4'h0, oscCurrent}, 8'h0C);
		dw(ADDR_CTRL, 8'h06);
		chk8({4'h0, oscCurrent}, {4'h0, OSC_RESET[3:0]});
		dw(ADDR_CTRL, 8'h07);
		dw(ADDR_OSC, 8'h3C);
		dr(ADDR_OSC);
		chk8(v, 8'h3C);
		hr(4'hF);
		chk8(v, 8'h00);
	endtask
	task automatic t_lock();
		hw(HADDR_MASK, 8'h01);
		dw(ADDR_MOD, 8'h02);
		dw(ADDR_IF, 8'h03);
		dw(ADDR_CTRL, 8'h17);
		repeat (4) @(posedge core_clk);
		chk1(link.dataClock, 1'b1);
		dw(ADDR_CTRL, 8'h13);
		chk1(link.dataClock, 1'b1);
		waitFor(0, 1'b0, TON + 40);
		chk1(n + 8 >= TON && n <= TON + 10, 1'b1);
		// host sees the fall through its own synchroniser, irq a few cycles later
		repeat (5) @(posedge core_clk);
		#1;
		chk1(pllLocked & irq, 1'b1);
		hr(HADDR_STAT);
		chk8(v & 8'h01, 8'h01);
		hw(HADDR_MASK, 8'h00);
		chk1(irq, 1'b0);
		dw(ADDR_CTRL, 8'h53);
		chk1(link.dataClock, 1'b1);
		chk8({4'h0, oscCurrent}, 8'h03);
		waitFor(0, 1'b0, 60);
		chk1(irq, 1'b0);
		hw(HADDR_MASK, 8'h01);
		repeat (2) @(posedge core_clk);
		#1;
		chk1(irq, 1'b1);
		hr(HADDR_STAT);
		dw(ADDR_CTRL, 8'h43);
		lv = link.dataClock;
		waitFor(0, !lv, 4 * SDIV);
		chk1(link.dataClock, !lv);
		dw(ADDR_MOD, 8'h00);
		dw(ADDR_CTRL, 8'h17);
		chk1(link.dataClock, 1'b0);
	endtask
	task automatic t_pn9();
		logic s [0:39];
		hw(HADDR_DATA, 8'h01);
		dw(ADDR_CTRL, 8'h41);
		repeat (3 * SDIV) @(posedge core_clk);
		chk1(modBit, 1'b1);
		hw(HADDR_DATA, 8'h00);
		repeat (3 * SDIV) @(posedge core_clk);
		chk1(modBit, 1'b0);
		dw(ADDR_MOD, 8'h03);
		hw(HADDR_DATA, 8'h01);
		waitFor(1, 1'b1, 20 * SDIV);
		repeat (SDIV / 2) @(posedge core_clk);
		for (int i = 0; i < 40; i++) begin
			#1 s[i] = modBit;
			repeat (SDIV) @(posedge core_clk);
		end
		for (int i = 9; i < 40; i++) chk1(s[i], s[i - 5] ^ s[i - 9]);
	endtask
	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end
	initial begin
		rst = 1'b1;
		addr = 4'h0;
		wdata = 8'h00;
		wr = 1'b0;
		rd = 1'b0;
		errorCnt = 0;
		checks = 0;
		repeat (3) @(posedge core_clk);
		rst <= 1'b0;
		t_regs();
		t_lock();
		t_pn9();
		results();
	end
endmodule // tx_power_pn9_lock_control_tb
